// [testbench.sv]
/* Self-checking bench for the mixer: arithmetic, rounding, limits, format
   pipelining, delay loading and the register slave. Assumes the mixer, its
   checker and the delay loader model are compiled before it. */
`timescale 1ns/1ns
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin err_count++; \
   $display("unexpected at %0t: got %h, want %h", $time, a, e); end end
module testbench;
   logic ref_clk = 1'h0, rst = 1'h1, weight_load_enable = 1'h1, number_format_sel = 1'h1;
   logic bypass = 1'h1, out_enable_n = 1'h0, avs_read = 1'h0, avs_write = 1'h0, go = 1'h0;
   logic [11:0] pixel_in_first = 12'h000, pixel_in_second = 12'h000, weight_factor = 12'h000;
   logic [1:0] round_width_sel = 2'h3;
   logic [3:0] avs_address = 4'h0;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
   logic [12:0] mixed_result_out;
   logic [12:0] rx [4] = '{13'h0020, 13'h0018, 13'h0016, 13'h0016};
   logic busy, delay_shift_strobe, delay_serial_in, mixed_result_oe, avs_waitrequest;
   int err_count = 0, n_compared = 0, n0, n1;
   wtspm_mixer dut (.ref_clk(ref_clk), .rst(rst), .pixel_in_first(pixel_in_first),
      .pixel_in_second(pixel_in_second), .weight_factor(weight_factor),
      .weight_load_enable(weight_load_enable), .number_format_sel(number_format_sel),
      .round_width_sel(round_width_sel), .delay_shift_strobe(delay_shift_strobe),
      .delay_serial_in(delay_serial_in), .bypass(bypass), .out_enable_n(out_enable_n),
      .mixed_result_out(mixed_result_out), .mixed_result_oe(mixed_result_oe),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest));
   wtspm_delay_loader ldr (.ref_clk(ref_clk), .go(go), .word(15'h0007),
      .delay_shift_strobe(delay_shift_strobe), .delay_serial_in(delay_serial_in),
      .busy(busy));
   initial
      forever #10 ref_clk = !ref_clk;
   task summarize;
      $display("compared %0d, mismatched %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task av(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      avs_address <= a;
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= d;
      // Request stands until the rising edge that sees waitrequest low
      do @(posedge ref_clk); while (avs_waitrequest !== 1'h0);
      q = avs_readdata;
      avs_read <= 1'h0;
      avs_write <= 1'h0;
   endtask
   task hold(input logic [12:0] e);
      @(negedge ref_clk);
      `CHK(mixed_result_out, e)
      @(posedge ref_clk);
   endtask
   task mx(input logic [11:0] a, b, m, input logic [2:0] fr, input logic [12:0] e);
      {pixel_in_first, pixel_in_second, weight_factor} <= {a, b, m};
      {number_format_sel, round_width_sel} <= fr;
      repeat (16) @(posedge ref_clk);
      hold(e);
   endtask
   task lat(output int n);
      mx(12'h100, 12'h100, 12'h800, 3'h7, 13'h0200);
      pixel_in_first <= 12'h200;
      n = 0;
      do @(negedge ref_clk); while (mixed_result_out !== 13'h0400 && ++n < 40);
      @(posedge ref_clk);
   endtask
   initial
   begin
      repeat (20) @(posedge ref_clk);
      rst <= 1'h0;
      av(1'h0, 4'h0, 32'h0);
      `CHK(q, 32'h0)
      av(1'h0, 4'h8, 32'h0);
      `CHK(q, 32'h0)
      $display("test registers done");
      mx(12'h100, 12'h200, 12'h000, 3'h7, 13'h0400);
      mx(12'h100, 12'h200, 12'hFFF, 3'h7, 13'h0200);
      mx(12'h100, 12'h200, 12'h400, 3'h7, 13'h0300);
      weight_load_enable <= 1'h0;
      mx(12'h100, 12'h200, 12'h000, 3'h7, 13'h0300);
      weight_load_enable <= 1'h1;
      for (int i = 0; i < 4; i++)
         mx(12'h00B, 12'h00B, 12'h800, {1'h1, i[1:0]}, rx[i]);
      mx(12'hFFF, 12'hFFF, 12'h800, 3'h4, 13'h1FE0);
      mx(12'h7FF, 12'h7FF, 12'h800, 3'h4, 13'h1000);
      mx(12'h7FF, 12'h7FF, 12'h800, 3'h0, 13'h0FE0);
      {number_format_sel, round_width_sel} <= 3'h7;
      repeat (2) @(posedge ref_clk);
      hold(13'h0FE0);
      mx(12'h7FF, 12'h7FF, 12'h800, 3'h7, 13'h0FFE);
      mx(12'h800, 12'h800, 12'h800, 3'h3, 13'h1000);
      av(1'h0, 4'h4, 32'h0);
      `CHK(q[0], 1'h1)
      av(1'h1, 4'h4, 32'h1);
      av(1'h0, 4'h4, 32'h0);
      `CHK(q[0], 1'h0)
      out_enable_n <= 1'h1;
      @(negedge ref_clk);
      `CHK(mixed_result_oe, 1'h0)
      @(posedge ref_clk);
      out_enable_n <= 1'h0;
      $display("test mixing done");
      lat(n0);
      go <= 1'h1;
      @(posedge ref_clk);
      go <= 1'h0;
      do @(negedge ref_clk); while (busy);
      av(1'h0, 4'h4, 32'h0);
      `CHK(q[30:16], 15'h0000)
      bypass <= 1'h0;
      repeat (4) @(posedge ref_clk);
      av(1'h0, 4'h4, 32'h0);
      `CHK(q[30:16], 15'h0007)
      lat(n1);
      `CHK(n1 - n0, 7)
      av(1'h1, 4'h0, 32'h1);
      av(1'h0, 4'h4, 32'h0);
      `CHK(q[30:16], 15'h0000)
      $display("test delay done");
      summarize();
   end
   initial
   begin
      // About 460 clocks are needed; over eight times that means a hang
      #80000;
      err_count++;
      summarize();
   end
endmodule // testbench

// [wtspm_defines.vh]
/*
 * Constants for the weighted two-source pixel mixer: delay word field
 * positions, fixed-point scaling, rounding codes and register offsets.
 * Assumes inclusion by wtspm_mixer.v only; it holds definitions alone.
 */
`ifndef WTSPM_DEFINES_VH
`define WTSPM_DEFINES_VH

// Delay control word layout, three bits per path
`define WTSPM_DLY_WORD_W 15
`define WTSPM_FIELD_W 3
`define WTSPM_DLY_A_LSB 0
`define WTSPM_DLY_B_LSB 3
`define WTSPM_DLY_M_LSB 6
`define WTSPM_DLY_F_LSB 9
`define WTSPM_DLY_R_LSB 12
`define WTSPM_DLY_DEPTH 8

// Weight of exactly one with one integer bit, 11 fraction bits
`define WTSPM_WEIGHT_ONE 12'h800

// Fraction bits left in the sum once the doubling is applied
`define WTSPM_FRAC_BITS 10

// Rounding select codes and the low output bits each one clears
`define WTSPM_RND_8 2'b00
`define WTSPM_RND_10 2'b01
`define WTSPM_RND_12 2'b10
`define WTSPM_RND_13 2'b11
`define WTSPM_DROP_8 4'h5
`define WTSPM_DROP_10 4'h3
`define WTSPM_DROP_12 4'h1
`define WTSPM_DROP_13 4'h0

// Output limits
`define WTSPM_UNS_MAX 18'h01FFF
`define WTSPM_SGN_MAX 18'h00FFF
`define WTSPM_SGN_MIN 18'h3F000

// Avalon-MM register map, byte addresses
`define WTSPM_ADDR_CTRL 4'h0
`define WTSPM_ADDR_STATUS 4'h4
`define WTSPM_CTRL_BYPASS_BIT 0
`define WTSPM_STATUS_OVF_BIT 0
`define WTSPM_STATUS_DLY_LSB 16
`define WTSPM_CTRL_RESET 1'b0

`endif

// [wtspm_delay_loader.sv]
/* Model of the controller that loads the delay word: fifteen strobes, LSB
   first. Assumes go is raised for one ref_clk cycle while busy is low. */
`timescale 1ns/1ns
module wtspm_delay_loader
(
   input wire logic ref_clk,
   input wire logic go,
   input wire logic [14:0] word,
   output logic delay_shift_strobe,
   output logic delay_serial_in,
   output logic busy
);
   initial
   begin
      delay_shift_strobe = 1'h0;
      delay_serial_in = 1'h0;
      busy = 1'h0;
      forever
      begin
         @(posedge ref_clk);
         if (go)
         begin
            busy <= 1'h1;
            for (int i = 0; i < 15; i++)
            begin
               // Four clocks each side so the mixer's synchroniser sees a clean edge
               delay_serial_in <= word[i];
               repeat (4) @(posedge ref_clk);
               delay_shift_strobe <= 1'h1;
               repeat (4) @(posedge ref_clk);
               delay_shift_strobe <= 1'h0;
            end
            // Idle data flips so a stale bit is never mistaken for a held one
            delay_serial_in <= !word[14];
            busy <= 1'h0;
         end
      end
   end
endmodule // wtspm_delay_loader

// [wtspm_mixer.v]
/*
 * Weighted two-source pixel mixer: computes 2*(A*M + B*(1-M)) over a fixed
 * six-stage pipeline with programmable per-path alignment delays, rounding,
 * saturation and a small Avalon-MM control/status slave.
 * Assumes pixel, weight and format inputs are synchronous to ref_clk; the
 * delay strobe, serial data and bypass pins are asynchronous and are
 * synchronised here; the output enable pin acts combinationally.
 */
// The implementer's own choices: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ns
`include "wtspm_defines.vh"

module wtspm_mixer
#(
   parameter PIX_W = 12,
   parameter OUT_W = 13
)
(
   input wire ref_clk,
   input wire rst,
   input wire [PIX_W-1:0] pixel_in_first,
   input wire [PIX_W-1:0] pixel_in_second,
   input wire [PIX_W-1:0] weight_factor,
   input wire weight_load_enable,
   input wire number_format_sel,
   input wire [1:0] round_width_sel,
   input wire delay_shift_strobe,
   input wire delay_serial_in,
   input wire bypass,
   input wire out_enable_n,
   output wire [OUT_W-1:0] mixed_result_out,
   output wire mixed_result_oe,
   input wire [3:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [31:0] avs_writedata,
   input wire [3:0] avs_byteenable,
   output wire [31:0] avs_readdata,
   output wire avs_waitrequest
);

   // Low output bits cleared for a rounding select
   function [3:0] drop_bits;
      input [1:0] sel;
      begin
         case (sel)
            `WTSPM_RND_8: drop_bits = `WTSPM_DROP_8;
            `WTSPM_RND_10: drop_bits = `WTSPM_DROP_10;
            `WTSPM_RND_12: drop_bits = `WTSPM_DROP_12;
            default: drop_bits = `WTSPM_DROP_13;
         endcase
      end
   endfunction

   // Widen a pixel to 13-bit signed according to the format
   function signed [PIX_W:0] widen;
      input [PIX_W-1:0] pix;
      input uns;
      begin
         if (uns)
            widen = {1'b0, pix};
         else
            widen = {pix[PIX_W-1], pix};
      end
   endfunction

   integer i;

   // Asynchronous pin synchronisers
   reg bypass_s1_reg;
   reg bypass_s2_reg;
   reg strobe_s1_reg;
   reg strobe_s2_reg;
   reg strobe_s3_reg;
   reg serial_s1_reg;
   reg serial_s2_reg;
   reg [`WTSPM_DLY_WORD_W-1:0] delay_word_reg;

   // Stage 1 and the alignment chains
   reg [PIX_W-1:0] weight_reg;
   wire [PIX_W-1:0] weight_next;
   reg [PIX_W-1:0] a_dly_reg [0:`WTSPM_DLY_DEPTH-1];
   reg [PIX_W-1:0] b_dly_reg [0:`WTSPM_DLY_DEPTH-1];
   reg [PIX_W-1:0] m_dly_reg [0:`WTSPM_DLY_DEPTH-1];
   reg f_dly_reg [0:`WTSPM_DLY_DEPTH-1];
   reg [1:0] r_dly_reg [0:`WTSPM_DLY_DEPTH-1];

   // Stages 2 to 6
   reg [PIX_W-1:0] a2_reg;
   reg [PIX_W-1:0] b2_reg;
   reg [PIX_W-1:0] m2_reg;
   reg f2_reg;
   reg [1:0] r2_reg;
   reg signed [2*PIX_W+1:0] pa3_reg;
   reg signed [2*PIX_W+1:0] pb3_reg;
   reg f3_reg;
   reg [1:0] r3_reg;
   reg signed [2*PIX_W+2:0] sum4_reg;
   reg f4_reg;
   reg [1:0] r4_reg;
   reg signed [17:0] y5_reg;
   reg f5_reg;
   reg [1:0] r5_reg;
   reg [OUT_W-1:0] out_reg;
   reg ovf_pulse_reg;

   // Register slave
   reg ctrl_bypass_reg;
   reg ovf_sticky_reg;
   reg ack_reg;
   reg [31:0] readdata_reg;

   wire soft_bypass;
   wire [`WTSPM_DLY_WORD_W-1:0] eff_word;
   wire [`WTSPM_FIELD_W-1:0] tap_a;
   wire [`WTSPM_FIELD_W-1:0] tap_b;
   wire [`WTSPM_FIELD_W-1:0] tap_m;
   wire [`WTSPM_FIELD_W-1:0] tap_f;
   wire [`WTSPM_FIELD_W-1:0] tap_r;
   wire [PIX_W-1:0] one_minus_m;
   wire signed [PIX_W:0] m_signed;
   wire signed [PIX_W:0] n_signed;
   wire [3:0] drop5;
   wire signed [27:0] round_add;
   wire signed [27:0] rounded;
   wire [3:0] drop6;
   wire [17:0] keep_mask;
   wire [17:0] limit_hi;
   wire over_hi;
   wire under_lo;
   wire [17:0] sat_val;
   wire strobe_rise;
   wire bus_hit;
   wire wr_status_clr;

   // Sync stage 1 feeds only stage 2; the edge detect looks at later stages
   always @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         bypass_s1_reg <= 1'b0;
         bypass_s2_reg <= 1'b0;
         strobe_s1_reg <= 1'b0;
         strobe_s2_reg <= 1'b0;
         strobe_s3_reg <= 1'b0;
         serial_s1_reg <= 1'b0;
         serial_s2_reg <= 1'b0;
      end
      else
      begin
         bypass_s1_reg <= bypass;
         bypass_s2_reg <= bypass_s1_reg;
         strobe_s1_reg <= delay_shift_strobe;
         strobe_s2_reg <= strobe_s1_reg;
         strobe_s3_reg <= strobe_s2_reg;
         serial_s1_reg <= delay_serial_in;
         serial_s2_reg <= serial_s1_reg;
      end
   end

   // Data and strobe share synchroniser depth, so the bit seen at the rise is
   // the one presented with it; strobes must be slower than three clocks
   assign strobe_rise = strobe_s2_reg & ~strobe_s3_reg;

   always @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         delay_word_reg <= {`WTSPM_DLY_WORD_W{1'b0}};
      else if (strobe_rise)
         delay_word_reg <= {serial_s2_reg, delay_word_reg[`WTSPM_DLY_WORD_W-1:1]};
   end

   assign soft_bypass = bypass_s2_reg | ctrl_bypass_reg;
   assign eff_word = soft_bypass ? {`WTSPM_DLY_WORD_W{1'b0}} : delay_word_reg;
   assign tap_a = eff_word[`WTSPM_DLY_A_LSB +: `WTSPM_FIELD_W];
   assign tap_b = eff_word[`WTSPM_DLY_B_LSB +: `WTSPM_FIELD_W];
   assign tap_m = eff_word[`WTSPM_DLY_M_LSB +: `WTSPM_FIELD_W];
   assign tap_f = eff_word[`WTSPM_DLY_F_LSB +: `WTSPM_FIELD_W];
   assign tap_r = eff_word[`WTSPM_DLY_R_LSB +: `WTSPM_FIELD_W];

   // Stage 1 and alignment chains; element 0 is the input register
   always @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         weight_reg <= {PIX_W{1'b0}};
         for (i = 0; i < `WTSPM_DLY_DEPTH; i = i + 1)
         begin
            a_dly_reg[i] <= {PIX_W{1'b0}};
            b_dly_reg[i] <= {PIX_W{1'b0}};
            m_dly_reg[i] <= {PIX_W{1'b0}};
            f_dly_reg[i] <= 1'b0;
            r_dly_reg[i] <= 2'b00;
         end
      end
      else
      begin
         weight_reg <= weight_next;
         a_dly_reg[0] <= pixel_in_first;
         b_dly_reg[0] <= pixel_in_second;
         f_dly_reg[0] <= number_format_sel;
         r_dly_reg[0] <= round_width_sel;
         m_dly_reg[0] <= weight_next;
         for (i = 1; i < `WTSPM_DLY_DEPTH; i = i + 1)
         begin
            a_dly_reg[i] <= a_dly_reg[i-1];
            b_dly_reg[i] <= b_dly_reg[i-1];
            m_dly_reg[i] <= m_dly_reg[i-1];
            f_dly_reg[i] <= f_dly_reg[i-1];
            r_dly_reg[i] <= r_dly_reg[i-1];
         end
      end
   end

   // Weight enters its chain at the pixels' edge, so no path gains a stage
   assign weight_next = weight_load_enable ?
      (weight_factor[PIX_W-1] ? `WTSPM_WEIGHT_ONE : weight_factor) : weight_reg;
   assign one_minus_m = `WTSPM_WEIGHT_ONE - m2_reg;
   assign m_signed = {1'b0, m2_reg};
   assign n_signed = {1'b0, one_minus_m};

   assign drop5 = drop_bits(r4_reg);
   assign round_add = 28'sh0000001 <<< (`WTSPM_FRAC_BITS - 1 + drop5);
   assign rounded = {sum4_reg[2*PIX_W+2], sum4_reg} + round_add;

   assign drop6 = drop_bits(r5_reg);
   assign keep_mask = ~((18'h00001 << drop6) - 18'h00001);
   assign limit_hi = f5_reg ? `WTSPM_UNS_MAX : `WTSPM_SGN_MAX;
   assign over_hi = y5_reg > $signed(limit_hi);
   assign under_lo = !f5_reg && (y5_reg < $signed(`WTSPM_SGN_MIN));
   assign sat_val = over_hi ? limit_hi : (under_lo ? `WTSPM_SGN_MIN : y5_reg);

   // Stages 2 to 6: six edges from input sample to output in all when the path's alignment tap is zero
   always @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         a2_reg <= {PIX_W{1'b0}};
         b2_reg <= {PIX_W{1'b0}};
         m2_reg <= {PIX_W{1'b0}};
         f2_reg <= 1'b0;
         r2_reg <= 2'b00;
         pa3_reg <= {(2*PIX_W+2){1'b0}};
         pb3_reg <= {(2*PIX_W+2){1'b0}};
         f3_reg <= 1'b0;
         r3_reg <= 2'b00;
         sum4_reg <= {(2*PIX_W+3){1'b0}};
         f4_reg <= 1'b0;
         r4_reg <= 2'b00;
         y5_reg <= 18'h00000;
         f5_reg <= 1'b0;
         r5_reg <= 2'b00;
         out_reg <= {OUT_W{1'b0}};
         ovf_pulse_reg <= 1'b0;
      end
      else
      begin
         a2_reg <= a_dly_reg[tap_a];
         b2_reg <= b_dly_reg[tap_b];
         m2_reg <= m_dly_reg[tap_m];
         f2_reg <= f_dly_reg[tap_f];
         r2_reg <= r_dly_reg[tap_r];
         // Both sources share one format select, so mixed formats cannot occur
         pa3_reg <= widen(a2_reg, f2_reg) * m_signed;
         pb3_reg <= widen(b2_reg, f2_reg) * n_signed;
         f3_reg <= f2_reg;
         r3_reg <= r2_reg;
         sum4_reg <= {pa3_reg[2*PIX_W+1], pa3_reg} + {pb3_reg[2*PIX_W+1], pb3_reg};
         f4_reg <= f3_reg;
         r4_reg <= r3_reg;
         // Taking bits above the fraction point applies the doubling
         y5_reg <= rounded[27:`WTSPM_FRAC_BITS];
         f5_reg <= f4_reg;
         r5_reg <= r4_reg;
         out_reg <= sat_val[OUT_W-1:0] & keep_mask[OUT_W-1:0];
         ovf_pulse_reg <= over_hi | under_lo;
      end
   end

   // Three-state output; enable follows the pin with no clock
   assign mixed_result_out = out_reg;
   assign mixed_result_oe = ~out_enable_n;

   // Avalon-MM slave: one wait cycle, then the request completes
   assign bus_hit = (avs_read | avs_write) & ack_reg;
   assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
   assign avs_readdata = readdata_reg;
   assign wr_status_clr = bus_hit & avs_write & (avs_address == `WTSPM_ADDR_STATUS)
      & avs_byteenable[0] & avs_writedata[`WTSPM_STATUS_OVF_BIT];

   always @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         ack_reg <= 1'b0;
         readdata_reg <= 32'h00000000;
         ctrl_bypass_reg <= `WTSPM_CTRL_RESET;
         ovf_sticky_reg <= 1'b0;
      end
      else
      begin
         ack_reg <= (avs_read | avs_write) & ~ack_reg;
         // A new overflow wins over a clear in the same cycle
         if (ovf_pulse_reg)
            ovf_sticky_reg <= 1'b1;
         else if (wr_status_clr)
            ovf_sticky_reg <= 1'b0;
         if (bus_hit & avs_write & (avs_address == `WTSPM_ADDR_CTRL) & avs_byteenable[0])
            ctrl_bypass_reg <= avs_writedata[`WTSPM_CTRL_BYPASS_BIT];
         readdata_reg <= 32'h00000000;
         if (avs_read & ~ack_reg)
         begin
            case (avs_address)
               `WTSPM_ADDR_CTRL:
                  readdata_reg[`WTSPM_CTRL_BYPASS_BIT] <= ctrl_bypass_reg;
               `WTSPM_ADDR_STATUS:
               begin
                  readdata_reg[`WTSPM_STATUS_OVF_BIT] <= ovf_sticky_reg;
                  readdata_reg[`WTSPM_STATUS_DLY_LSB +: `WTSPM_DLY_WORD_W] <= eff_word;
               end
               default:
                  readdata_reg <= 32'h00000000;
            endcase
         end
      end
   end

endmodule // wtspm_mixer

// [wtspm_monitor.sv]
/* Checker for the mixer top: enable pin, rounding masks, plain sums, limits
   and the bus wait state. Assumes a zero delay word once bypass has stayed
   high for 31 clocks. */
`timescale 1ns/1ns
module wtspm_monitor
(
   input wire ref_clk,
   input wire rst,
   input wire [11:0] pixel_in_first,
   input wire [11:0] pixel_in_second,
   input wire number_format_sel,
   input wire [1:0] round_width_sel,
   input wire bypass,
   input wire out_enable_n,
   input wire [12:0] mixed_result_out,
   input wire mixed_result_oe,
   input wire avs_read,
   input wire avs_waitrequest
);
   // Covers the bypass synchroniser plus the deepest aligned path draining
   reg [4:0] byp_cnt_reg;
   always @(posedge ref_clk or posedge rst)
      if (rst || !bypass)
         byp_cnt_reg <= 5'h00;
      else if (byp_cnt_reg != 5'h1F)
         byp_cnt_reg <= byp_cnt_reg + 5'h01;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   // Two steady samples, so either latency reading sees the same operands
   sequence calm(c);
      (c && byp_cnt_reg == 5'h1F && $stable(pixel_in_first) && $stable(pixel_in_second)
         && $stable(number_format_sel) && $stable(round_width_sel)) [*2];
   endsequence
   oe_follow_a: assert property (mixed_result_oe == !out_enable_n)
      else $error("enable wrong");
   rnd_eight_a: assert property (calm(round_width_sel == 2'h0)
      |-> ##6 mixed_result_out[4:0] == 5'h00) else $error("8 bit mask");
   rnd_ten_a: assert property (calm(round_width_sel == 2'h1)
      |-> ##6 mixed_result_out[2:0] == 3'h0) else $error("10 bit mask");
   rnd_twelve_a: assert property (calm(round_width_sel == 2'h2)
      |-> ##6 mixed_result_out[0] == 1'h0) else $error("12 bit mask");
   sum_pass_a: assert property (calm(pixel_in_first == pixel_in_second
      && round_width_sel == 2'h3) |-> ##6 mixed_result_out == {$past(pixel_in_first, 6), 1'h0})
      else $error("sum wrong");
   sat_uns_a: assert property (calm(number_format_sel && pixel_in_first == 12'hFFF
      && pixel_in_second == 12'hFFF && round_width_sel == 2'h0)
      |-> ##6 mixed_result_out == 13'h1FE0) else $error("no top limit");
   sat_sgn_a: assert property (calm(!number_format_sel && pixel_in_first == 12'h7FF
      && pixel_in_second == 12'h7FF && round_width_sel == 2'h0)
      |-> ##6 mixed_result_out == 13'h0FE0) else $error("no signed limit");
   wait_ack_a: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
      else $error("wait state wrong");
endmodule // wtspm_monitor
bind wtspm_mixer wtspm_monitor mon (.ref_clk, .rst, .pixel_in_first, .pixel_in_second,
   .number_format_sel, .round_width_sel, .bypass, .out_enable_n, .mixed_result_out,
   .mixed_result_oe, .avs_read, .avs_waitrequest);
